// ==== ufcam_pkg.sv ====
package ufcam_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_PWR = 12'h004;
   localparam logic [11:0] ADDR_RXDIV = 12'h008;
   localparam logic [11:0] ADDR_TXDIV = 12'h00c;
   localparam logic [11:0] ADDR_TXDATA = 12'h010;
   localparam logic [11:0] ADDR_RXDATA = 12'h014;
   localparam logic [11:0] ADDR_ISTAT = 12'h018;
   localparam logic [11:0] ADDR_ICLR = 12'h01c;
   localparam logic [11:0] ADDR_IEN = 12'h020;
   localparam logic [7:0] IDX_OWN_ADDR = 8'ha9;
   localparam logic [7:0] IDX_OWN_MASK = 8'hb9;
   localparam logic [11:0] ADDR_OWN_ADDR = {2'b00, IDX_OWN_ADDR, 2'b00};
   localparam logic [11:0] ADDR_OWN_MASK = {2'b00, IDX_OWN_MASK, 2'b00};
   // reset values
   localparam logic [7:0] RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] RST_OWN_MASK = 8'h00;
   localparam logic [15:0] RST_DIV = 16'h0000;
   // field positions
   localparam int CTRL_RI = 0;
   localparam int CTRL_TI = 1;
   localparam int CTRL_RB9 = 2;
   localparam int CTRL_TB9 = 3;
   localparam int CTRL_REN = 4;
   localparam int CTRL_MPE = 5;
   localparam int CTRL_MODE = 6;
   localparam int CTRL_FE = 8;
   localparam int PWR_FCE = 0;
   localparam int IRQ_RX = 0;
   localparam int IRQ_TX = 1;
   localparam int IRQ_FE = 2;
   // bit timing in oversample ticks, frame lengths in bits
   localparam logic [3:0] PHASE_LAST = 4'hf;
   localparam logic [3:0] PHASE_MID = 4'h7;
   localparam logic [3:0] BITS_DATA8 = 4'h8;
   localparam logic [3:0] BITS_DATA9 = 4'h9;
   localparam logic [3:0] BITS_FRAME8 = 4'ha;
   localparam logic [3:0] BITS_FRAME9 = 4'hb;

   typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} ufcam_mode_e;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [11:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ufcam_wbreq_s;

   typedef struct packed {
      logic [8:0] data;
      logic stopOk;
   } ufcam_frame_s;

   function automatic logic addrMatch(input logic [7:0] rx,
         input logic [7:0] own, input logic [7:0] mask);
      logic [7:0] given;
      logic [7:0] bcast;
      given = own & mask;
      bcast = own | mask;
      return ((rx & mask) == given) || ((rx & bcast) == bcast);
   endfunction

   function automatic logic [15:0] lane16(input logic [15:0] old,
         input logic [15:0] wd, input logic [1:0] sel);
      return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
   endfunction
endpackage

// ==== ufcam_rx.sv ====
module ufcam_rx (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstN,
   // line and setup
   input wire logic rxd,
   input wire logic enable,
   input wire logic nineBits,
   input wire logic [15:0] div,
   // received frame
   output ufcam_pkg::ufcam_frame_s frame,
   output logic dataEnd,
   output logic stopEnd
);
   import ufcam_pkg::*;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufcam_rxst_e;
   ufcam_rxst_e state_reg;
   logic [15:0] divCnt_reg;
   logic [3:0] phase_reg;
   logic [3:0] bitCnt_reg;
   logic [8:0] shift_reg;
   logic [8:0] shiftNext;
   logic tick;
   assign tick = (divCnt_reg == div);
   assign shiftNext = {rxd, shift_reg[8:1]};

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) divCnt_reg <= 16'h0000;
      else divCnt_reg <= tick ? 16'h0000 : divCnt_reg + 16'h0001;
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         state_reg <= RX_IDLE;
         phase_reg <= 4'h0;
         bitCnt_reg <= 4'h0;
         shift_reg <= 9'h000;
         frame <= '0;
         dataEnd <= 1'b0;
         stopEnd <= 1'b0;
      end else begin
         dataEnd <= 1'b0;
         stopEnd <= 1'b0;
         if (tick) begin
            phase_reg <= phase_reg + 4'h1;
            case (state_reg)
               RX_IDLE: begin
                  phase_reg <= 4'h0;
                  if (enable && !rxd) state_reg <= RX_START;
               end
               RX_START: if (phase_reg == PHASE_MID) begin
                  phase_reg <= 4'h0;
                  bitCnt_reg <= 4'h0;
                  state_reg <= rxd ? RX_IDLE : RX_DATA;
               end
               RX_DATA: if (phase_reg == PHASE_LAST) begin
                  shift_reg <= shiftNext;
                  bitCnt_reg <= bitCnt_reg + 4'h1;
                  if (bitCnt_reg == (nineBits ? BITS_DATA9 : BITS_DATA8)
                        - 4'h1) begin
                     state_reg <= RX_STOP;
                     dataEnd <= 1'b1;
                     frame.data <= nineBits ? shiftNext
                           : {1'b0, shiftNext[8:1]};
                  end
               end
               RX_STOP: if (phase_reg == PHASE_LAST) begin
                  stopEnd <= 1'b1;
                  frame.stopOk <= rxd;
                  state_reg <= RX_IDLE;
               end
               default: state_reg <= RX_IDLE;
            endcase
         end
      end
   end
endmodule

// ==== ufcam_tx.sv ====
module ufcam_tx (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstN,
   // request
   input wire logic start,
   input wire logic [8:0] data,
   input wire logic nineBits,
   input wire logic [15:0] div,
   // line and status
   output logic txd,
   output logic busy,
   output logic done
);
   import ufcam_pkg::*;
   logic [15:0] divCnt_reg;
   logic [3:0] phase_reg;
   logic [3:0] bitsLeft_reg;
   logic [10:0] shift_reg;
   logic tick;
   assign tick = (divCnt_reg == div);
   assign busy = (bitsLeft_reg != 4'h0);

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) divCnt_reg <= 16'h0000;
      else divCnt_reg <= (tick || start) ? 16'h0000 : divCnt_reg + 16'h0001;
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         phase_reg <= 4'h0;
         bitsLeft_reg <= 4'h0;
         shift_reg <= 11'h7ff;
         txd <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            shift_reg <= nineBits ? {1'b1, data, 1'b0}
                  : {2'b11, data[7:0], 1'b0};
            bitsLeft_reg <= nineBits ? BITS_FRAME9 : BITS_FRAME8;
            phase_reg <= 4'h0;
            txd <= 1'b0;
         end else if (busy && tick) begin
            phase_reg <= phase_reg + 4'h1;
            if (phase_reg == PHASE_LAST) begin
               shift_reg <= {1'b1, shift_reg[10:1]};
               txd <= shift_reg[1];
               bitsLeft_reg <= bitsLeft_reg - 4'h1;
               if (bitsLeft_reg == 4'h1) begin
                  done <= 1'b1;
                  txd <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// ==== ufcam_top.sv ====
// Notes on behaviour
// - full-duplex serial port, receive and send together, separate baud rates.
// - stop-bit checking only in modes 1-3 and only while enable set.
// - with checking on, a bad stop bit sets the framing error flag.
// - framing error flag sticks until software or reset clears it.
// - with checking on, receive-done rises at the stop bit.
// - address recognition is on whenever multiprocessor enable is set in modes 1-3.
// - with recognition on, receive-done sets only for matching address frames.
// - mode 1 recognition needs address match and a valid stop bit.
// - an address frame matches on given address or broadcast address.
// - in mode 0 multiprocessor enable does nothing at all.
// - reset clears own address and mask, so any address matches.
//
// Our own choice: the Wishbone slave port.
module ufcam_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // wishbone slave
   input ufcam_pkg::ufcam_wbreq_s wbReq,
   output logic wbAck,
   output logic [31:0] wbDatOut,
   // serial line
   input wire logic rxd,
   output logic txd,
   // interrupt
   output logic irq
);
   import ufcam_pkg::*;

   logic [1:0] rstSync_reg;
   logic rstN;
   logic wbAck_reg;
   logic [31:0] wbDat_reg;
   logic wrStrobe;
   logic wrCtrl;
   ufcam_mode_e mode_reg;
   logic mpEnable_reg;
   logic rxEnable_reg;
   logic txNinth_reg;
   logic rxNinth_reg;
   logic riFlag_reg;
   logic tiFlag_reg;
   logic feFlag_reg;
   logic fcEnable_reg;
   logic [15:0] rxDiv_reg;
   logic [15:0] txDiv_reg;
   logic [7:0] ownAddr_reg;
   logic [7:0] ownMask_reg;
   logic [7:0] rxData_reg;
   logic [2:0] istat_reg;
   logic [2:0] ien_reg;
   logic [2:0] istatSet;
   logic [31:0] rdData;
   ufcam_frame_s frame;
   logic dataEnd;
   logic stopEnd;
   logic nineBits;
   logic fcActive;
   logic mpActive;
   logic evtPoint;
   logic matchOk;
   logic pass;
   logic rxAccept;
   logic feSet;
   logic txStart;
   logic txBusy;
   logic txDone;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) rstSync_reg <= 2'b00;
      else rstSync_reg <= {rstSync_reg[0], 1'b1};
   end
   assign rstN = rstSync_reg[1];

   // bus slave: ack one cycle after the request, one cycle wide
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) wbAck_reg <= 1'b0;
      else wbAck_reg <= wbReq.cyc && wbReq.stb && !wbAck_reg;
   end
   assign wbAck = wbAck_reg;
   assign wbDatOut = wbDat_reg;
   assign wrStrobe = wbReq.cyc && wbReq.stb && wbReq.we && wbAck_reg;
   assign wrCtrl = wrStrobe && (wbReq.adr == ADDR_CTRL);

   always_comb begin
      rdData = 32'h0000_0000;
      case (wbReq.adr)
         ADDR_CTRL: begin
            rdData[CTRL_RI] = riFlag_reg;
            rdData[CTRL_TI] = tiFlag_reg;
            rdData[CTRL_RB9] = rxNinth_reg;
            rdData[CTRL_TB9] = txNinth_reg;
            rdData[CTRL_REN] = rxEnable_reg;
            rdData[CTRL_MPE] = mpEnable_reg;
            rdData[CTRL_MODE +: 2] = mode_reg;
            rdData[CTRL_FE] = feFlag_reg;
         end
         ADDR_PWR: rdData[PWR_FCE] = fcEnable_reg;
         ADDR_RXDIV: rdData[15:0] = rxDiv_reg;
         ADDR_TXDIV: rdData[15:0] = txDiv_reg;
         ADDR_RXDATA: rdData[7:0] = rxData_reg;
         ADDR_ISTAT: rdData[2:0] = istat_reg;
         ADDR_IEN: rdData[2:0] = ien_reg;
         ADDR_OWN_ADDR: rdData[7:0] = ownAddr_reg;
         ADDR_OWN_MASK: rdData[7:0] = ownMask_reg;
         default: rdData = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) wbDat_reg <= 32'h0000_0000;
      else if (wbReq.cyc && wbReq.stb && !wbAck_reg) wbDat_reg <= rdData;
   end

   // serial control fields written by software
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         mode_reg <= MODE0;
         mpEnable_reg <= 1'b0;
         rxEnable_reg <= 1'b0;
         txNinth_reg <= 1'b0;
      end else if (wrCtrl && wbReq.sel[0]) begin
         mode_reg <= ufcam_mode_e'(wbReq.dat[CTRL_MODE +: 2]);
         mpEnable_reg <= wbReq.dat[CTRL_MPE];
         rxEnable_reg <= wbReq.dat[CTRL_REN];
         txNinth_reg <= wbReq.dat[CTRL_TB9];
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) fcEnable_reg <= 1'b0;
      else if (wrStrobe && wbReq.adr == ADDR_PWR && wbReq.sel[0])
         fcEnable_reg <= wbReq.dat[PWR_FCE];
   end

   // independent baud dividers for each direction
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rxDiv_reg <= RST_DIV;
         txDiv_reg <= RST_DIV;
      end else if (wrStrobe) begin
         if (wbReq.adr == ADDR_RXDIV)
            rxDiv_reg <= lane16(rxDiv_reg, wbReq.dat[15:0], wbReq.sel[1:0]);
         if (wbReq.adr == ADDR_TXDIV)
            txDiv_reg <= lane16(txDiv_reg, wbReq.dat[15:0], wbReq.sel[1:0]);
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         ownAddr_reg <= RST_OWN_ADDR;
         ownMask_reg <= RST_OWN_MASK;
      end else if (wrStrobe && wbReq.sel[0]) begin
         if (wbReq.adr == ADDR_OWN_ADDR) ownAddr_reg <= wbReq.dat[7:0];
         if (wbReq.adr == ADDR_OWN_MASK) ownMask_reg <= wbReq.dat[7:0];
      end
   end

   // receive path
   assign nineBits = (mode_reg == MODE2) || (mode_reg == MODE3);
   assign fcActive = fcEnable_reg && (mode_reg != MODE0);
   assign mpActive = mpEnable_reg && (mode_reg != MODE0);
   // mode 1 recognition needs the stop bit, so it also waits for it
   assign evtPoint = (fcActive || (mpActive && mode_reg == MODE1))
         ? stopEnd : dataEnd;
   assign matchOk = addrMatch(frame.data[7:0], ownAddr_reg,
         ownMask_reg);

   always_comb begin
      if (!mpActive) pass = 1'b1;
      else if (mode_reg == MODE1) pass = matchOk && frame.stopOk;
      else pass = frame.data[8] && matchOk;
   end

   assign rxAccept = evtPoint && pass;
   assign feSet = stopEnd && fcActive && !frame.stopOk;

   ufcam_rx ufcam_rx_inst (
      .clk_sys(clk_sys),
      .rstN(rstN),
      .rxd(rxd),
      .enable(rxEnable_reg),
      .nineBits(nineBits),
      .div(rxDiv_reg),
      .frame(frame),
      .dataEnd(dataEnd),
      .stopEnd(stopEnd)
   );

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rxData_reg <= 8'h00;
         rxNinth_reg <= 1'b0;
      end else if (rxAccept) begin
         rxData_reg <= frame.data[7:0];
         rxNinth_reg <= nineBits ? frame.data[8] : frame.stopOk;
      end
   end

   // sticky flags: hardware set wins over a software clear
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         riFlag_reg <= 1'b0;
         tiFlag_reg <= 1'b0;
      end else begin
         riFlag_reg <= rxAccept || (riFlag_reg && !(wrCtrl
               && wbReq.sel[0] && !wbReq.dat[CTRL_RI]));
         tiFlag_reg <= txDone || (tiFlag_reg && !(wrCtrl
               && wbReq.sel[0] && !wbReq.dat[CTRL_TI]));
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) feFlag_reg <= 1'b0;
      else feFlag_reg <= feSet || (feFlag_reg && !(wrCtrl
            && wbReq.sel[1] && !wbReq.dat[CTRL_FE]));
   end

   // transmit path runs alongside the receiver
   assign txStart = wrStrobe && (wbReq.adr == ADDR_TXDATA)
         && wbReq.sel[0] && !txBusy;

   ufcam_tx ufcam_tx_inst (
      .clk_sys(clk_sys),
      .rstN(rstN),
      .start(txStart),
      .data({txNinth_reg, wbReq.dat[7:0]}),
      .nineBits(nineBits),
      .div(txDiv_reg),
      .txd(txd),
      .busy(txBusy),
      .done(txDone)
   );

   // interrupt status, clear and enable
   always_comb begin
      istatSet = 3'b000;
      istatSet[IRQ_RX] = rxAccept;
      istatSet[IRQ_TX] = txDone;
      istatSet[IRQ_FE] = feSet;
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) istat_reg <= 3'b000;
      else if (wrStrobe && wbReq.adr == ADDR_ICLR && wbReq.sel[0])
         istat_reg <= istatSet | (istat_reg & ~wbReq.dat[2:0]);
      else istat_reg <= istatSet | istat_reg;
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) ien_reg <= 3'b000;
      else if (wrStrobe && wbReq.adr == ADDR_IEN && wbReq.sel[0])
         ien_reg <= wbReq.dat[2:0];
   end

   assign irq = |(istat_reg & ien_reg);

   // checks
   AST_FE_SET: assert property (
         @(posedge clk_sys) disable iff (!rstN) feSet |=> feFlag_reg)
      else $error("bad stop bit did not raise framing error");

   AST_FE_STICKY: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         feFlag_reg && !(wrCtrl && wbReq.sel[1]) |=> feFlag_reg)
      else $error("framing error dropped without software clear");

   AST_FE_MODE: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(feFlag_reg) |-> $past(fcEnable_reg)
         && $past(mode_reg) != MODE0)
      else $error("framing error raised with checking inactive");

   AST_FE_CAUSE: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(feFlag_reg) |-> $past(stopEnd) && !$past(frame.stopOk))
      else $error("framing error raised without a bad stop bit");

   AST_RI_AT_STOP: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(riFlag_reg) && $past(fcActive) |-> $past(stopEnd))
      else $error("receive done not at stop bit while checking");

   AST_RI_AT_DATA: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         dataEnd && !fcActive && !mpActive ##1 1 |-> riFlag_reg)
      else $error("receive done missing at last data bit");

   AST_MATCH: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(riFlag_reg) && $past(mpActive)
         |-> $past(matchOk))
      else $error("receive done for a foreign address");

   AST_IRQ_MATCH: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(istat_reg[IRQ_RX]) && $past(mpActive)
         |-> $past(matchOk))
      else $error("receive interrupt for a foreign address");

   AST_MODE1_STOP: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(riFlag_reg) && $past(mpActive && mode_reg == MODE1)
         |-> $past(stopEnd && frame.stopOk))
      else $error("mode 1 address frame accepted without stop bit");

   AST_NINTH: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         $rose(riFlag_reg) && $past(mpActive && nineBits)
         |-> $past(frame.data[8]))
      else $error("data frame accepted as address frame");

   AST_MODE0: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         dataEnd && mode_reg == MODE0 |=> riFlag_reg)
      else $error("mode 0 frame filtered");

   AST_BCAST: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         ((frame.data[7:0] & (ownAddr_reg | ownMask_reg))
         == (ownAddr_reg | ownMask_reg)) |-> matchOk)
      else $error("broadcast address not recognised");

   AST_RESET_ADDR: assert property (
         @(posedge clk_sys)
         $rose(rstN) |-> ownAddr_reg == 8'h00
         && ownMask_reg == 8'h00 && matchOk)
      else $error("address registers not cleared by reset");

   AST_RESET_FLAGS: assert property (
         @(posedge clk_sys)
         $rose(rstN) |-> !feFlag_reg && !riFlag_reg && !irq)
      else $error("flags not cleared by reset");

   AST_TX_DUPLEX: assert property (
         @(posedge clk_sys) disable iff (!rstN)
         txStart |=> txBusy [*8])
      else $error("transmit did not start");

   AST_ACK: assert property (@(posedge clk_sys) disable iff (!rstN)
         wbAck |=> !wbAck)
      else $error("ack longer than one cycle");

   COV_FE: cover property (@(posedge clk_sys) disable iff (!rstN)
         $rose(feFlag_reg));
   COV_MP_ACCEPT: cover property (@(posedge clk_sys) disable iff (!rstN)
         rxAccept && mpActive);
   COV_MP_REJECT: cover property (@(posedge clk_sys) disable iff (!rstN)
         evtPoint && mpActive && !pass);
   COV_TX_RX: cover property (@(posedge clk_sys) disable iff (!rstN)
         txBusy && stopEnd);
   COV_NINTH_ACCEPT: cover property (@(posedge clk_sys) disable iff (!rstN)
         rxAccept && mpActive && nineBits);
endmodule

// ==== ufcam_far_end.sv ====
// another station on the shared serial line: sends and receives frames
module ufcam_far_end #(
   parameter int BIT = 16
) (
   // clock
   input wire logic clk_sys,
   // serial line
   output logic lineOut,
   input wire logic lineIn
);
   timeunit 1ns;
   timeprecision 1ps;

   // line idles high between frames
   initial lineOut = 1'b1;

   // start bit, nb data bits lsb first, then the given stop level
   task automatic sendFrame(input logic [8:0] d, input int nb,
         input logic stp);
      int i;
      @(posedge clk_sys);
      lineOut <= 1'b0;
      repeat (BIT) @(posedge clk_sys);
      for (i = 0; i < nb; i++) begin
         lineOut <= d[i];
         repeat (BIT) @(posedge clk_sys);
      end
      lineOut <= stp;
      repeat (BIT) @(posedge clk_sys);
      lineOut <= 1'b1;
   endtask

   // samples mid-bit; ok only when a high stop bit was seen
   task automatic recvFrame(input int nb, output logic [8:0] d,
         output logic ok);
      int i;
      d = '0;
      ok = 1'b0;
      for (i = 0; i < 2000 && lineIn !== 1'b0; i++) @(posedge clk_sys);
      if (lineIn !== 1'b0) return;
      repeat (BIT / 2) @(posedge clk_sys);
      for (i = 0; i < nb; i++) begin
         repeat (BIT) @(posedge clk_sys);
         d[i] = lineIn;
      end
      repeat (BIT) @(posedge clk_sys);
      ok = (lineIn === 1'b1);
   endtask
endmodule

// ==== tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ufcam_pkg::*;

   logic clk_sys;
   logic reset_n;
   ufcam_wbreq_s wbReq;
   logic wbAck;
   logic [31:0] wbDatOut;
   logic rxd;
   logic txd;
   logic irq;
   logic [31:0] ctlv;
   logic [8:0] txb;
   logic ok;
   int badCount;
   int nTests;

   ufcam_top ufcam_top_inst (.clk_sys(clk_sys), .reset_n(reset_n),
      .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .rxd(rxd),
      .txd(txd), .irq(irq));

   ufcam_far_end ufcam_far_end_inst (.clk_sys(clk_sys), .lineOut(rxd),
      .lineIn(txd));

   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      nTests++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         badCount++;
      end
   endtask

   task automatic stopTest();
      if (badCount == 0 && nTests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // one wishbone classic cycle, then one idle cycle
   task automatic wb(input logic we, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      int i;
      wbReq <= '{1'b1, 1'b1, we, a, s, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_sys);
         if (wbAck === 1'b1) break;
      end
      if (i == 20) begin
         chk("wbAck", 32'h1, 32'h0);
         stopTest();
      end
      q = wbDatOut;
      wbReq <= '0;
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, a, d, s, q);
   endtask

   task automatic rdm(input string nm, input logic [11:0] a,
         input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hf, q);
      chk(nm, e, q & m);
   endtask

   task automatic setc(input logic [1:0] m, input logic mpe);
      ctlv = (32'(m) << CTRL_MODE) | (32'(mpe) << CTRL_MPE) |
         (32'h1 << CTRL_REN);
      wr(ADDR_CTRL, ctlv, 4'h1);
   endtask

   // send a frame, check receive-done, then clear it
   task automatic rxchk(input logic [8:0] d, input int nb,
         input logic stp, input logic [31:0] e);
      ufcam_far_end_inst.sendFrame(d, nb, stp);
      repeat (8) @(posedge clk_sys);
      rdm("rxDone", ADDR_CTRL, 32'h1, e);
      wr(ADDR_CTRL, ctlv, 4'h1);
   endtask

   // receive-done read between last data sample and stop sample
   task automatic early(input logic [8:0] d, input logic stp,
         input logic [31:0] e);
      fork
         ufcam_far_end_inst.sendFrame(d, 8, stp);
         begin
            repeat (144) @(posedge clk_sys);
            rdm("rxDoneAtData", ADDR_CTRL, 32'h1, e);
         end
      join
      repeat (8) @(posedge clk_sys);
   endtask

   initial begin
      reset_n = 1'b0;
      wbReq = '0;
      badCount = 0;
      nTests = 0;
      repeat (20) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdm("ownAddr", ADDR_OWN_ADDR, 32'hff, 32'h0);
      rdm("ownMask", ADDR_OWN_MASK, 32'hff, 32'h0);
      rdm("unmapped", 12'h100, 32'hffffffff, 32'h0);
      setc(2'd1, 1'b1);
      rxchk(9'h077, 8, 1'b1, 32'h1);
      setc(2'd1, 1'b0);
      early(9'h05a, 1'b1, 32'h1);
      rdm("rxData", ADDR_RXDATA, 32'hff, 32'h5a);
      rdm("istat", ADDR_ISTAT, 32'h1, 32'h1);
      chk("irqMasked", 32'h0, {31'h0, irq});
      wr(ADDR_IEN, 32'h1, 4'h1);
      chk("irqOn", 32'h1, {31'h0, irq});
      wr(ADDR_ICLR, 32'h1, 4'h1);
      rdm("istatClr", ADDR_ISTAT, 32'h1, 32'h0);
      chk("irqOff", 32'h0, {31'h0, irq});
      wr(ADDR_CTRL, ctlv, 4'h1);
      wr(ADDR_PWR, 32'h1, 4'h1);
      early(9'h0a5, 1'b0, 32'h0);
      rdm("frameErr", ADDR_CTRL, 32'h100, 32'h100);
      rdm("istatFe", ADDR_ISTAT, 32'h4, 32'h4);
      wr(ADDR_CTRL, ctlv, 4'h1);
      rxchk(9'h03c, 8, 1'b1, 32'h1);
      rdm("frameErrHeld", ADDR_CTRL, 32'h100, 32'h100);
      wr(ADDR_CTRL, ctlv, 4'h3);
      rdm("frameErrClr", ADDR_CTRL, 32'h100, 32'h0);
      wr(ADDR_OWN_ADDR, 32'h12, 4'h1);
      wr(ADDR_OWN_MASK, 32'hff, 4'h1);
      setc(2'd0, 1'b1);
      rxchk(9'h034, 8, 1'b0, 32'h1);
      rdm("frameErrMode0", ADDR_CTRL, 32'h100, 32'h0);
      setc(2'd1, 1'b1);
      rxchk(9'h034, 8, 1'b1, 32'h0);
      rxchk(9'h012, 8, 1'b0, 32'h0);
      rxchk(9'h012, 8, 1'b1, 32'h1);
      rxchk(9'h0ff, 8, 1'b1, 32'h1);
      wr(ADDR_OWN_MASK, 32'hf0, 4'h1);
      rxchk(9'h01e, 8, 1'b1, 32'h1);
      rxchk(9'h02e, 8, 1'b1, 32'h0);
      wr(ADDR_OWN_MASK, 32'hff, 4'h1);
      setc(2'd3, 1'b1);
      rxchk(9'h012, 9, 1'b1, 32'h0);
      rxchk(9'h112, 9, 1'b1, 32'h1);
      fork
         wr(ADDR_TXDATA, 32'hc3, 4'h1);
         ufcam_far_end_inst.recvFrame(9, txb, ok);
         ufcam_far_end_inst.sendFrame(9'h112, 9, 1'b1);
      join
      chk("txData", 32'h0c3, {23'h0, txb});
      chk("txStop", 32'h1, {31'h0, ok});
      rdm("rxDuplex", ADDR_RXDATA, 32'hff, 32'h12);
      rdm("txDone", ADDR_ISTAT, 32'h2, 32'h2);
      stopTest();
   end
endmodule
